//--- avl_pkg.sv
// Package of constants for the access violation logger
// =====================================================================
// What this block does
// - Initiator code in source byte bits 7-4; 1 core, 3/4 converters, 5 trigger.
// - Target code in source byte bits 3-0; register, RAM, EEPROM, flash, info row.
// - Access kind code in upper nibble of low byte: opcode, vector, load, store.
// - Fault kind code in lower nibble of low byte: illegal range or ECC.
// - A core access violation loads a non-zero code pair.
// - Program counter and flag snapshot are captured with the code pair.
// - While the code pair is non-zero the log is not updated (only the dropped status bit is set); first fault kept.
// - A 16-bit write of all ones clears both code bytes; reads always allowed.
// - High flag snapshot bit 7 holds user state, read-only, refreshed per error.
// - Low flag snapshot bit 6 holds X mask, read-only, refreshed per error.
// - Low flag snapshot bit 4 holds I mask, read-only, refreshed per error.
// - The 24-bit faulting program counter reads as high, middle, low bytes.
// - After a clear the program counter snapshot is undefined until next fault.
// - Every illegal access by the core raises a machine exception.
// - Uncorrectable ECC by core, converter or trigger raises machine exception.
// =====================================================================
package avl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_SRC_TGT   = 10'h080;
    localparam logic [9:0] IDX_ACC_ERR   = 10'h081;
    localparam logic [9:0] IDX_FLAGS_HI  = 10'h082;
    localparam logic [9:0] IDX_FLAGS_LO  = 10'h083;
    localparam logic [9:0] IDX_PC_HI     = 10'h085;
    localparam logic [9:0] IDX_PC_MID    = 10'h086;
    localparam logic [9:0] IDX_PC_LO     = 10'h087;
    localparam logic [9:0] IDX_CODE_PAIR = 10'h090;
    localparam logic [9:0] IDX_IRQ_STS   = 10'h091;
    localparam logic [9:0] IDX_IRQ_MASK  = 10'h092;
    // Field positions
    localparam int USER_BIT  = 7;
    localparam int XMASK_BIT = 6;
    localparam int IMASK_BIT = 4;
    localparam int STS_LOGGED  = 0;
    localparam int STS_DROPPED = 1;
    localparam int STS_W       = 2;
    // Codes
    localparam logic [3:0] INIT_NONE = 4'h0;
    localparam logic [3:0] INIT_CORE = 4'h1;
    localparam logic [3:0] INIT_CONV0 = 4'h3;
    localparam logic [3:0] INIT_CONV1 = 4'h4;
    localparam logic [3:0] INIT_TRIG = 4'h5;
    localparam logic [3:0] FAULT_ILLEGAL = 4'h1;
    localparam logic [3:0] FAULT_ECC     = 4'h2;
    // Clear value and reset values
    localparam logic [15:0] CLEAR_KEY  = 16'hffff;
    localparam logic [15:0] PAIR_RST   = 16'h0000;
    localparam logic [23:0] PC_RST     = 24'h000000;
    localparam logic [STS_W-1:0] STS_RST  = 2'h0;
    localparam logic [STS_W-1:0] MASK_RST = 2'h0;
endpackage : avl_pkg

//--- avl_logger.sv
// Access violation logger with APB register access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module avl_logger #(
    parameter int ADDR_W = 12,   // APB byte address width
    parameter int PC_W   = 24    // Captured program counter width
) (
    input  wire logic              sys_clk,       // System clock, 100 MHz
    input  wire logic              sys_rst,       // Sync reset, active high
    input  wire logic              sys_ce,        // Clock enable, freezes all
    input  wire logic              psel,          // APB select
    input  wire logic              penable,       // APB access phase
    input  wire logic              pwrite,        // APB direction
    input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
    input  wire logic [31:0]       pwdata,        // APB write data
    output logic      [31:0]       prdata,        // APB read data
    output logic                   pready,        // APB ready
    output logic                   pslverr,       // APB error
    input  wire logic              viol_valid,    // Violation seen this cycle
    input  wire logic [3:0]        viol_init,     // Initiator code
    input  wire logic [3:0]        viol_target,   // Target code
    input  wire logic [3:0]        viol_access,   // Access kind code
    input  wire logic [3:0]        viol_fault,    // Fault kind code
    input  wire logic              core_user,     // Core user state
    input  wire logic              core_xmask,    // Core X-interrupt mask
    input  wire logic              core_imask,    // Core I-interrupt mask
    input  wire logic [PC_W-1:0]   core_pc,       // Faulting instruction PC
    output logic                   mach_exc,      // Machine exception pulse
    output logic                   irq            // Level interrupt
);
    // =================================================================
    // Elaboration checks
    generate
        if (PC_W != 24) begin : g_bad_pc
            $error("avl_logger: PC_W must be 24");
        end
        if (ADDR_W < 12) begin : g_bad_addr
            $error("avl_logger: ADDR_W must be at least 12");
        end
    endgenerate

    // =================================================================
    // State
    logic [15:0]       pair_r;
    logic              user_r;
    logic              xmask_r;
    logic              imask_r;
    logic [PC_W-1:0]   pc_r;
    logic [avl_pkg::STS_W-1:0] sts_r;
    logic [avl_pkg::STS_W-1:0] mask_r;
    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    logic              mach_exc_r;
    logic              irq_r;

    // =================================================================
    // Decoding
    function automatic logic is_mapped(input logic [9:0] idx);
        is_mapped = (idx == avl_pkg::IDX_SRC_TGT)
                 || (idx == avl_pkg::IDX_ACC_ERR)
                 || (idx == avl_pkg::IDX_FLAGS_HI)
                 || (idx == avl_pkg::IDX_FLAGS_LO)
                 || (idx == avl_pkg::IDX_PC_HI)
                 || (idx == avl_pkg::IDX_PC_MID)
                 || (idx == avl_pkg::IDX_PC_LO)
                 || (idx == avl_pkg::IDX_CODE_PAIR)
                 || (idx == avl_pkg::IDX_IRQ_STS)
                 || (idx == avl_pkg::IDX_IRQ_MASK);
    endfunction : is_mapped

    wire logic [9:0]  idx_w      = paddr[11:2];
    wire logic        upper_zero = (ADDR_W == 12) ? 1'b1
                                   : ~|(paddr >> 12);
    wire logic        hit_w      = is_mapped(idx_w) && upper_zero
                                   && (paddr[1:0] == 2'b00);
    wire logic        setup_w    = sys_ce && psel && !penable;
    wire logic        wr_done_w  = sys_ce && psel && penable && pready_r
                                   && pwrite && !pslverr_r;
    wire logic        wr_pair_w  = wr_done_w
                                   && (idx_w == avl_pkg::IDX_CODE_PAIR);
    wire logic        wr_sts_w   = wr_done_w
                                   && (idx_w == avl_pkg::IDX_IRQ_STS);
    wire logic        wr_mask_w  = wr_done_w
                                   && (idx_w == avl_pkg::IDX_IRQ_MASK);

    // =================================================================
    // Capture and clear
    wire logic [15:0] code_w     = {viol_init, viol_target,
                                    viol_access, viol_fault};
    wire logic        empty_w    = (pair_r == avl_pkg::PAIR_RST);
    wire logic        event_w    = sys_ce && viol_valid && (code_w != 16'h0);
    // Only an empty log takes a new fault, so the first one survives
    wire logic        cap_w      = event_w && empty_w;
    wire logic        drop_w     = event_w && !empty_w;
    // Any other value is a plain write that leaves the log alone
    wire logic        clr_w      = wr_pair_w
                                   && (pwdata[15:0] == avl_pkg::CLEAR_KEY);

    wire logic        exc_w      = sys_ce && viol_valid
        && (((viol_init == avl_pkg::INIT_CORE)
             && (viol_fault == avl_pkg::FAULT_ILLEGAL))
         || ((viol_fault == avl_pkg::FAULT_ECC)
             && ((viol_init == avl_pkg::INIT_CORE)
              || (viol_init == avl_pkg::INIT_CONV0)
              || (viol_init == avl_pkg::INIT_CONV1)
              || (viol_init == avl_pkg::INIT_TRIG))));

    // A capture in the clear cycle wins; a fault arriving as a held fault is cleared is dropped
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pair_r <= avl_pkg::PAIR_RST;
        end else if (cap_w) begin
            pair_r <= code_w;
        end else if (clr_w) begin
            pair_r <= avl_pkg::PAIR_RST;
        end
    end

    // PC is left as is by a clear; it only means something when logged
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pc_r    <= avl_pkg::PC_RST;
            user_r  <= 1'b0;
            xmask_r <= 1'b0;
            imask_r <= 1'b0;
        end else if (cap_w) begin
            pc_r    <= core_pc;
            user_r  <= core_user;
            xmask_r <= core_xmask;
            imask_r <= core_imask;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mach_exc_r <= 1'b0;
        end else if (sys_ce) begin
            mach_exc_r <= exc_w;
        end
    end

    // =================================================================
    // Interrupt status, mask and output
    wire logic [avl_pkg::STS_W-1:0] sts_set_w = {drop_w, cap_w};
    wire logic [avl_pkg::STS_W-1:0] sts_clr_w =
        wr_sts_w ? pwdata[avl_pkg::STS_W-1:0] : '0;
    wire logic [avl_pkg::STS_W-1:0] sts_nxt = (sts_r & ~sts_clr_w)
                                              | sts_set_w;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sts_r  <= avl_pkg::STS_RST;
            mask_r <= avl_pkg::MASK_RST;
            irq_r  <= 1'b0;
        end else if (sys_ce) begin
            sts_r  <= sts_nxt;
            if (wr_mask_w) begin
                mask_r <= pwdata[avl_pkg::STS_W-1:0];
            end
            irq_r  <= |(sts_r & mask_r);
        end
    end

    // =================================================================
    // APB read mux and handshake
    wire logic [7:0] flags_hi_w = {user_r, 7'h00};
    wire logic [7:0] flags_lo_w = {1'b0, xmask_r, 1'b0, imask_r, 4'h0};
    logic [31:0] rd_w;
    always_comb begin
        rd_w = 32'h0;
        if (idx_w == avl_pkg::IDX_SRC_TGT) begin
            rd_w = {24'h0, pair_r[15:8]};
        end else if (idx_w == avl_pkg::IDX_ACC_ERR) begin
            rd_w = {24'h0, pair_r[7:0]};
        end else if (idx_w == avl_pkg::IDX_FLAGS_HI) begin
            rd_w = {24'h0, flags_hi_w};
        end else if (idx_w == avl_pkg::IDX_FLAGS_LO) begin
            rd_w = {24'h0, flags_lo_w};
        end else if (idx_w == avl_pkg::IDX_PC_HI) begin
            rd_w = {24'h0, pc_r[23:16]};
        end else if (idx_w == avl_pkg::IDX_PC_MID) begin
            rd_w = {24'h0, pc_r[15:8]};
        end else if (idx_w == avl_pkg::IDX_PC_LO) begin
            rd_w = {24'h0, pc_r[7:0]};
        end else if (idx_w == avl_pkg::IDX_CODE_PAIR) begin
            rd_w = {16'h0, pair_r};
        end else if (idx_w == avl_pkg::IDX_IRQ_STS) begin
            rd_w = {30'h0, sts_r};
        end else if (idx_w == avl_pkg::IDX_IRQ_MASK) begin
            rd_w = {30'h0, mask_r};
        end
    end

    // One wait-free access: ready is raised for the first access cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else if (sys_ce) begin
            pready_r  <= setup_w;
            pslverr_r <= setup_w && !hit_w;
            if (setup_w && !pwrite && hit_w) begin
                prdata_r <= rd_w;
            end
        end
    end

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign mach_exc = mach_exc_r;
    assign irq      = irq_r;

    // =================================================================
    // Assertions
    property p_capture;
        @(posedge sys_clk) disable iff (sys_rst)
        cap_w |=> (pair_r == $past(code_w)) && (pair_r != 16'h0);
    endproperty
    a_capture: assert property (p_capture)
        else $error("log not loaded by violation");

    property p_fields;
        @(posedge sys_clk) disable iff (sys_rst)
        cap_w |=> (pair_r[15:12] == $past(viol_init))
               && (pair_r[11:8] == $past(viol_target))
               && (pair_r[7:4] == $past(viol_access))
               && (pair_r[3:0] == $past(viol_fault));
    endproperty
    a_fields: assert property (p_fields)
        else $error("code fields misplaced");

    property p_snap;
        @(posedge sys_clk) disable iff (sys_rst)
        cap_w |=> (pc_r == $past(core_pc)) && (user_r == $past(core_user))
               && (xmask_r == $past(core_xmask))
               && (imask_r == $past(core_imask));
    endproperty
    a_snap: assert property (p_snap)
        else $error("snapshot not captured with code");

    property p_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (!empty_w && !clr_w) |=> $stable(pair_r) && $stable(pc_r)
                                 && $stable(user_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("log changed while holding a fault");

    property p_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        (clr_w && !cap_w) |=> (pair_r == 16'h0) && empty_w;
    endproperty
    a_clear: assert property (p_clear)
        else $error("all-ones write did not clear log");

    property p_nonkey;
        @(posedge sys_clk) disable iff (sys_rst)
        (wr_done_w && !clr_w && !cap_w) |=> $stable(pair_r)
                                            && $stable(pc_r);
    endproperty
    a_nonkey: assert property (p_nonkey)
        else $error("ignored write changed the log");

    property p_exc_core;
        @(posedge sys_clk) disable iff (sys_rst)
        (sys_ce && viol_valid && viol_init == 4'h1 && viol_fault == 4'h1)
        |=> mach_exc;
    endproperty
    a_exc_core: assert property (p_exc_core)
        else $error("core illegal access without exception");

    property p_exc_ecc;
        @(posedge sys_clk) disable iff (sys_rst)
        (sys_ce && viol_valid && viol_fault == 4'h2 && viol_init == 4'h5)
        |=> mach_exc;
    endproperty
    a_exc_ecc: assert property (p_exc_ecc)
        else $error("ECC fault without exception");

    property p_pc_read;
        @(posedge sys_clk) disable iff (sys_rst)
        (setup_w && !pwrite && paddr == 12'h214) |=>
            pready && (prdata[7:0] == pc_r[23:16]);
    endproperty
    a_pc_read: assert property (p_pc_read)
        else $error("PC high byte read wrong");

    property p_irq;
        @(posedge sys_clk) disable iff (sys_rst)
        (sys_ce && |(sts_r & mask_r)) |=> irq ##1 1'b1;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked status without interrupt");

    c_capture: cover property (@(posedge sys_clk) disable iff (sys_rst)
        cap_w ##[1:20] clr_w);
    c_drop: cover property (@(posedge sys_clk) disable iff (sys_rst)
        drop_w);
    c_race: cover property (@(posedge sys_clk) disable iff (sys_rst)
        cap_w && clr_w);
    c_irq: cover property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(irq));
endmodule : avl_logger
`default_nettype wire

//--- avl_viol_src.sv
// Model of the core and bus masters that report access violations
`timescale 1ns/100ps
`default_nettype none
module avl_viol_src (
    input  wire logic        sys_clk,     // System clock
    output logic             viol_valid,  // Violation strobe
    output logic [3:0]       viol_init,   // Initiator code
    output logic [3:0]       viol_target, // Target code
    output logic [3:0]       viol_access, // Access kind code
    output logic [3:0]       viol_fault,  // Fault kind code
    output logic             core_user,   // Core user state
    output logic             core_xmask,  // Core X mask
    output logic             core_imask,  // Core I mask
    output logic [23:0]      core_pc      // Faulting PC
);
    initial begin
        viol_valid = 1'b0;
        {viol_init, viol_target, viol_access, viol_fault} = 16'h0000;
        {core_user, core_xmask, core_imask, core_pc} = 27'h0000000;
    end

    // =================================================================
    // Report one violation, after lag + 1 idle cycles
    task automatic fire(input logic [15:0] code, input logic [2:0] flg,
                        input logic [23:0] pc, input int lag);
        repeat (lag) @(posedge sys_clk);
        @(posedge sys_clk);
        viol_valid <= 1'b1;
        {viol_init, viol_target, viol_access, viol_fault} <= code;
        {core_user, core_xmask, core_imask} <= flg;
        core_pc <= pc;
        @(posedge sys_clk);
        viol_valid <= 1'b0;
        // Junk outside a report, so a late sample shows up as wrong data
        {viol_init, viol_target, viol_access, viol_fault} <= ~code;
        {core_user, core_xmask, core_imask} <= ~flg;
        core_pc <= ~pc;
    endtask : fire
endmodule : avl_viol_src
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the access violation logger
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        sys_clk, sys_rst, sys_ce, psel, penable, pwrite;
    logic        pready, pslverr, viol_valid, mach_exc, irq, err;
    logic        core_user, core_xmask, core_imask;
    logic [3:0]  viol_init, viol_target, viol_access, viol_fault;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, r;
    logic [23:0] core_pc;
    logic [15:0] code;
    logic [3:0]  inits [4] = '{4'h1, 4'h3, 4'h4, 4'h5};
    int          failures, checked;
    int          cycles = 0;

    avl_logger #(.ADDR_W(12), .PC_W(24)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(sys_ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .viol_valid(viol_valid),
        .viol_init(viol_init), .viol_target(viol_target),
        .viol_access(viol_access), .viol_fault(viol_fault),
        .core_user(core_user), .core_xmask(core_xmask),
        .core_imask(core_imask), .core_pc(core_pc),
        .mach_exc(mach_exc), .irq(irq));
    avl_viol_src u_src (
        .sys_clk(sys_clk), .viol_valid(viol_valid),
        .viol_init(viol_init), .viol_target(viol_target),
        .viol_access(viol_access), .viol_fault(viol_fault),
        .core_user(core_user), .core_xmask(core_xmask),
        .core_imask(core_imask), .core_pc(core_pc));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // =================================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // ECC faults raise an exception only for core, converters and trigger
    function automatic logic exp_exc(input logic [15:0] c);
        logic ecc_src;
        ecc_src = (c[15:12] == 4'h1) || (c[15:12] == 4'h3)
               || (c[15:12] == 4'h4) || (c[15:12] == 4'h5);
        return (c[3:0] == 4'h1 && c[15:12] == 4'h1)
            || (c[3:0] == 4'h2 && ecc_src);
    endfunction : exp_exc

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1

    // Answer and error are taken at the edge that sees pready high;
    // only the global timeout ends a wait that never gets an answer
    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk32(rd, exp);
    endtask : rchk

    task automatic log_chk(input logic [15:0] c, input logic [2:0] f,
                           input logic [23:0] pc);
        rchk(avl_pkg::IDX_SRC_TGT, {24'h0, c[15:8]});
        rchk(avl_pkg::IDX_ACC_ERR, {24'h0, c[7:0]});
        rchk(avl_pkg::IDX_CODE_PAIR, {16'h0, c});
        rchk(avl_pkg::IDX_FLAGS_HI, {24'h0, f[2], 7'h0});
        rchk(avl_pkg::IDX_FLAGS_LO,
             {25'h0, f[1], 1'b0, f[0], 4'h0});
        rchk(avl_pkg::IDX_PC_HI, {24'h0, pc[23:16]});
        rchk(avl_pkg::IDX_PC_MID, {24'h0, pc[15:8]});
        rchk(avl_pkg::IDX_PC_LO, {24'h0, pc[7:0]});
    endtask : log_chk

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    // =================================================================
    // Main sequence
    initial begin
        logic [15:0] c2;
        logic [2:0]  f;
        logic [23:0] pc;
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        failures = 0;
        checked = 0;
        seed = 32'h0000000b;
        sys_ce = 1'b1;
        sys_rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        log_chk(16'h0000, 3'h0, 24'h000000);
        rchk(avl_pkg::IDX_IRQ_STS, 32'h0);
        apb(1'b0, 10'h0f0, 32'h0);
        chk1(err, 1'b1);
        // A violation while the clock enable is low must leave no trace
        sys_ce <= 1'b0;
        u_src.fire(16'h1111, 3'h7, 24'h123456, 0);
        sys_ce <= 1'b1;
        #1 chk1(mach_exc, 1'b0);
        rchk(avl_pkg::IDX_CODE_PAIR, 32'h0);
        $display("test reset and decode done");
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            code = {inits[k % 4], r[7:4], r[11:8], 3'h0, r[0]};
            code[1] = ~r[0];
            f = r[14:12];
            pc = 24'(rnd());
            c2 = {r[31:28], r[27:24], r[23:20], 4'h2};
            apb(1'b1, avl_pkg::IDX_IRQ_MASK, {31'h0, k[0]});
            u_src.fire(code, f, pc, k % 3);
            #1 chk1(mach_exc, exp_exc(code));
            @(posedge sys_clk);
            #1 chk1(irq, k[0]);
            log_chk(code, f, pc);
            u_src.fire(c2, ~f, ~pc, 0);
            #1 chk1(mach_exc, exp_exc(c2));
            rchk(avl_pkg::IDX_IRQ_STS, 32'h3);
            apb(1'b1, avl_pkg::IDX_CODE_PAIR, 32'h0000fffe);
            apb(1'b1, avl_pkg::IDX_SRC_TGT, 32'h000000ff);
            apb(1'b1, avl_pkg::IDX_FLAGS_LO, 32'h000000ff);
            apb(1'b1, avl_pkg::IDX_PC_LO, 32'h000000ff);
            chk1(err, 1'b0);
            log_chk(code, f, pc);
            apb(1'b1, avl_pkg::IDX_CODE_PAIR, 32'h0000ffff);
            rchk(avl_pkg::IDX_CODE_PAIR, 32'h0);
            rchk(avl_pkg::IDX_SRC_TGT, 32'h0);
            rchk(avl_pkg::IDX_ACC_ERR, 32'h0);
            apb(1'b1, avl_pkg::IDX_IRQ_STS, 32'h3);
            @(posedge sys_clk);
            #1 chk1(irq, 1'b0);
            rchk(avl_pkg::IDX_IRQ_STS, 32'h0);
            $display("test violation %0d done", k);
        end
        finish_test();
    end
endmodule : testbench
`default_nettype wire
